// *** rcr_pkg.sv ***
// Constants and types for the reset cause recorder
package rcr_pkg;
  localparam int RCR_ADDR_W = 4;
  localparam int RCR_DATA_W = 8;
  localparam int RCR_PC_W = 15;
  localparam logic [RCR_ADDR_W-1:0] RCR_OFS_POWER_CONTROL_FLAGS = 4'h0;
  localparam logic [RCR_ADDR_W-1:0] RCR_OFS_CORE_STATUS_FLAGS = 4'h1;
  localparam logic [RCR_PC_W-1:0] RCR_RESET_VECTOR = 15'h0000;
  localparam logic [RCR_PC_W-1:0] RCR_IRQ_VECTOR = 15'h0004;

  typedef struct packed {
    logic stack_over_flag;
    logic stack_under_flag;
    logic unused_5;
    logic watchdog_reset_flag_n;
    logic ext_pin_reset_flag_n;
    logic reset_instr_flag_n;
    logic poweron_flag_n;
    logic brownout_flag_n;
  } rcr_power_control_flags_t;

  typedef struct packed {
    logic [2:0] unused_hi;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic [2:0] unused_lo;
  } rcr_status_t;

  // Power-on values; brown-out bit is unknown on the part, chosen as 0
  localparam rcr_power_control_flags_t RCR_POWER_CONTROL_FLAGS_POR = 8'h18 | 8'h04;
  localparam rcr_status_t RCR_STATUS_POR = 8'h18;

  typedef struct packed {
    logic poweron;
    logic brownout;
    logic lp_brownout;
    logic prog_exit;
    logic ext_pin;
    logic watchdog;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
  } rcr_cause_t;

  typedef enum logic [2:0] {
    RCR_ST_RUN = 3'h1,
    RCR_ST_WAKE_EXEC = 3'h2,
    RCR_ST_VECTOR = 3'h4
  } rcr_state_t;
endpackage : rcr_pkg

// *** rcr_top.sv ***
// Reset cause recorder: power control and status flags with cause tracking
//
// Contract
// - Pin reset running: PC zero, clear pin flag
// - Pin reset asleep: timeout one, powerdown zero
// - Watchdog wake: next instruction, clear timeout, powerdown
// - Interrupt wake: next instruction, timeout one, powerdown zero
// - Enabled interrupt wake: execute next, then vector
// - Reset instruction: PC zero, clear its flag
// - Enabled overflow: reset to zero, set flag
// - Enabled underflow: reset to zero, set flag
// - Overflow flag bit 7, firmware clears
// - Underflow flag bit 6, firmware clears
// - Watchdog flag bit 4, hardware clears
// - Pin flag bit 3, hardware clears
// - Instruction flag bit 2, hardware clears
// - Power-on flag bit 1 cleared on power-on
// - Brown-out flag bit 0 cleared on brown-out
// - Bit 5 reads zero, ignores writes
// - Power-on and brown-out initialise cause flags; brown-out leaves watchdog flag bit 4 and power-on flag bit 1 unchanged
// - Low-power monitor clears same brown-out flag
// - Watchdog reset also updates status flags
// - Programming exit behaves as power-on
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module rcr_top
  import rcr_pkg::*;
#(
  parameter int PC_W = RCR_PC_W
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [RCR_ADDR_W-1:0] ADDR,
  input wire logic [RCR_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [RCR_DATA_W-1:0] RDATA,
  input wire logic POWERON_REQ,
  input wire logic BROWNOUT_REQ,
  input wire logic LP_BROWNOUT_REQ,
  input wire logic PROG_MODE_EXIT,
  input wire logic EXT_PIN_RESET,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic RESET_INSTR,
  input wire logic STACK_OVERFLOW,
  input wire logic STACK_UNDERFLOW,
  input wire logic STACK_FAULT_RESET_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IRQ_WAKE,
  input wire logic IN_SLEEP,
  input wire logic SLEEP_ENTER,
  input wire logic CLEAR_WATCHDOG,
  input wire logic INSTR_DONE,
  output logic PC_LOAD,
  output logic [PC_W-1:0] PC_ADDR,
  output logic PC_CONTINUE,
  output logic STACK_PUSH
);

  // Vectors are fixed at the package width, so a different PC width cannot be served
  if (PC_W != RCR_PC_W) begin : g_bad_pc_w
    $error("rcr_top: PC_W must equal the vector width");
  end

  rcr_power_control_flags_t power_control_flags_ff;
  rcr_power_control_flags_t nxt_power_control_flags;
  rcr_status_t status_ff;
  rcr_status_t nxt_status;
  rcr_state_t state_ff;
  rcr_state_t nxt_state;
  rcr_cause_t cause;
  logic [RCR_DATA_W-1:0] rdata_ff;
  logic [RCR_DATA_W-1:0] nxt_rdata;
  logic pc_load_ff;
  logic [PC_W-1:0] pc_addr_ff;
  logic pc_continue_ff;
  logic stack_push_ff;

  function automatic logic hit(input logic [RCR_ADDR_W-1:0] a,
                               input logic [RCR_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire wr_power_control_flags = WR && hit(ADDR, RCR_OFS_POWER_CONTROL_FLAGS);
  wire rd_power_control_flags = RD && hit(ADDR, RCR_OFS_POWER_CONTROL_FLAGS);
  wire rd_status = RD && hit(ADDR, RCR_OFS_CORE_STATUS_FLAGS);
  // Power-on class: power-on request and programming exit share one path
  wire poweron_any = POWERON_REQ || PROG_MODE_EXIT;
  wire brownout_any = BROWNOUT_REQ || LP_BROWNOUT_REQ;
  wire over_rst = STACK_FAULT_RESET_ENABLE && STACK_OVERFLOW;
  wire under_rst = STACK_FAULT_RESET_ENABLE && STACK_UNDERFLOW;
  wire wdt_reset = WATCHDOG_TIMEOUT && !IN_SLEEP;
  wire wdt_wake = WATCHDOG_TIMEOUT && IN_SLEEP;
  wire irq_wake = IRQ_WAKE && IN_SLEEP;
  wire any_reset = poweron_any || brownout_any || EXT_PIN_RESET || wdt_reset ||
                   RESET_INSTR || over_rst || under_rst;
  wire any_wake = !any_reset && (wdt_wake || irq_wake);

  assign cause = '{poweron: poweron_any, brownout: brownout_any,
                   lp_brownout: LP_BROWNOUT_REQ, prog_exit: PROG_MODE_EXIT,
                   ext_pin: EXT_PIN_RESET, watchdog: WATCHDOG_TIMEOUT,
                   reset_instr: RESET_INSTR, stack_over: over_rst,
                   stack_under: under_rst};

  // Firmware write first, hardware events after, so a hardware event wins a firmware write
  always_comb begin
    nxt_power_control_flags = power_control_flags_ff;
    if (wr_power_control_flags) begin
      nxt_power_control_flags = rcr_power_control_flags_t'(WDATA);
    end
    nxt_power_control_flags.unused_5 = 1'b0;
    if (cause.poweron) begin
      nxt_power_control_flags = RCR_POWER_CONTROL_FLAGS_POR;
    end else begin
      if (cause.brownout) begin
        nxt_power_control_flags.stack_over_flag = 1'b0;
        nxt_power_control_flags.stack_under_flag = 1'b0;
        nxt_power_control_flags.ext_pin_reset_flag_n = 1'b1;
        nxt_power_control_flags.reset_instr_flag_n = 1'b1;
        nxt_power_control_flags.brownout_flag_n = 1'b0;
      end
      if (cause.ext_pin) begin
        nxt_power_control_flags.ext_pin_reset_flag_n = 1'b0;
      end
      if (wdt_reset) begin
        nxt_power_control_flags.watchdog_reset_flag_n = 1'b0;
      end
      if (cause.reset_instr) begin
        nxt_power_control_flags.reset_instr_flag_n = 1'b0;
      end
      if (cause.stack_over) begin
        nxt_power_control_flags.stack_over_flag = 1'b1;
      end
      if (cause.stack_under) begin
        nxt_power_control_flags.stack_under_flag = 1'b1;
      end
    end
  end

  // Status flags are not writable by software, as on the real core
  always_comb begin
    nxt_status = status_ff;
    if (CLEAR_WATCHDOG) begin
      nxt_status.timeout_flag_n = 1'b1;
      nxt_status.powerdown_flag_n = 1'b1;
    end
    if (SLEEP_ENTER) begin
      nxt_status.timeout_flag_n = 1'b1;
      nxt_status.powerdown_flag_n = 1'b0;
    end
    if (cause.poweron || cause.brownout) begin
      nxt_status = RCR_STATUS_POR;
    end else if (EXT_PIN_RESET && IN_SLEEP) begin
      nxt_status.timeout_flag_n = 1'b1;
      nxt_status.powerdown_flag_n = 1'b0;
    end else if (wdt_reset) begin
      nxt_status.timeout_flag_n = 1'b0;
    end else if (wdt_wake && !any_reset) begin
      nxt_status.timeout_flag_n = 1'b0;
      nxt_status.powerdown_flag_n = 1'b0;
    end else if (irq_wake && !any_reset) begin
      nxt_status.timeout_flag_n = 1'b1;
      nxt_status.powerdown_flag_n = 1'b0;
    end
  end

  // Wake sequencing; a reset always aborts a pending vector
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RCR_ST_RUN: begin
        if (any_wake && irq_wake && !wdt_wake && GLOBAL_IRQ_ENABLE) begin
          nxt_state = RCR_ST_WAKE_EXEC;
        end
      end
      RCR_ST_WAKE_EXEC: begin
        if (INSTR_DONE) begin
          nxt_state = RCR_ST_VECTOR;
        end
      end
      RCR_ST_VECTOR: nxt_state = RCR_ST_RUN;
      default: nxt_state = RCR_ST_RUN;
    endcase
    if (any_reset) begin
      nxt_state = RCR_ST_RUN;
    end
  end

  wire vector_go = (state_ff == RCR_ST_VECTOR) && !any_reset;
  wire nxt_pc_load = any_reset || vector_go;
  wire [PC_W-1:0] nxt_pc_addr = any_reset ? RCR_RESET_VECTOR :
                                vector_go ? RCR_IRQ_VECTOR : pc_addr_ff;
  wire nxt_pc_continue = any_wake;

  always_comb begin
    nxt_rdata = '0;
    if (rd_power_control_flags) begin
      nxt_rdata = power_control_flags_ff;
    end else if (rd_status) begin
      nxt_rdata = status_ff;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      power_control_flags_ff <= RCR_POWER_CONTROL_FLAGS_POR;
      status_ff <= RCR_STATUS_POR;
      state_ff <= RCR_ST_RUN;
    end else begin
      power_control_flags_ff <= nxt_power_control_flags;
      status_ff <= nxt_status;
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rdata_ff <= '0;
      pc_load_ff <= 1'b0;
      pc_addr_ff <= RCR_RESET_VECTOR;
      pc_continue_ff <= 1'b0;
      stack_push_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      pc_load_ff <= nxt_pc_load;
      pc_addr_ff <= nxt_pc_addr;
      pc_continue_ff <= nxt_pc_continue;
      stack_push_ff <= vector_go;
    end
  end

  assign RDATA = rdata_ff;
  assign PC_LOAD = pc_load_ff;
  assign PC_ADDR = pc_addr_ff;
  assign PC_CONTINUE = pc_continue_ff;
  assign STACK_PUSH = stack_push_ff;

endmodule : rcr_top

// *** rcr_top_properties.sv ***
// Port checker for the reset cause recorder
`timescale 1ns/1ns
module rcr_checker
  import rcr_pkg::*;
#(parameter int PC_W = RCR_PC_W) (
  input wire logic MCLK, RST_N, RD, POWERON_REQ, BROWNOUT_REQ, LP_BROWNOUT_REQ,
  input wire logic PROG_MODE_EXIT, EXT_PIN_RESET, WATCHDOG_TIMEOUT, RESET_INSTR,
  input wire logic STACK_OVERFLOW, STACK_UNDERFLOW, STACK_FAULT_RESET_ENABLE,
  input wire logic GLOBAL_IRQ_ENABLE, IRQ_WAKE, IN_SLEEP, INSTR_DONE,
  input wire logic [RCR_ADDR_W-1:0] ADDR,
  input wire logic [RCR_DATA_W-1:0] RDATA,
  input wire logic PC_LOAD, PC_CONTINUE, STACK_PUSH,
  input wire logic [PC_W-1:0] PC_ADDR
);
  wire por_like = POWERON_REQ | BROWNOUT_REQ | LP_BROWNOUT_REQ | PROG_MODE_EXIT;
  wire stk = STACK_FAULT_RESET_ENABLE & (STACK_OVERFLOW | STACK_UNDERFLOW);
  wire rst_any = por_like | EXT_PIN_RESET | RESET_INSTR | stk | (WATCHDOG_TIMEOUT & ~IN_SLEEP);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_vec_wake;
    IRQ_WAKE && IN_SLEEP && GLOBAL_IRQ_ENABLE && !rst_any;
  endsequence
  sequence s_exec_done;
    INSTR_DONE && !rst_any ##1 !rst_any;
  endsequence
  a_pin_pc_zero: assert property (EXT_PIN_RESET |=> PC_LOAD && PC_ADDR == '0)
    else $error("pin reset missed address zero");
  a_instr_pc_zero: assert property (RESET_INSTR |=> PC_LOAD && PC_ADDR == '0)
    else $error("reset instruction missed address zero");
  a_stack_pc_zero: assert property (stk |=> PC_LOAD && PC_ADDR == '0)
    else $error("stack fault missed address zero");
  a_wake_next_instr: assert property ((IN_SLEEP && (IRQ_WAKE || WATCHDOG_TIMEOUT) && !rst_any)
    |=> PC_CONTINUE && !PC_LOAD)
    else $error("wake did not continue");
  a_vector_after_exec: assert property (s_vec_wake ##1 s_exec_done
    |=> STACK_PUSH && PC_LOAD && PC_ADDR == RCR_IRQ_VECTOR)
    else $error("interrupt vector missed");
  a_push_with_vector: assert property (STACK_PUSH |-> PC_ADDR == RCR_IRQ_VECTOR && !PC_CONTINUE)
    else $error("push without vector");
  a_unused_bit_zero: assert property (RD && ADDR == RCR_OFS_POWER_CONTROL_FLAGS |=> !RDATA[5])
    else $error("unused bit read as one");
  a_rdata_idle_zero: assert property (!RD |=> RDATA == '0)
    else $error("read data outside read slot");
endmodule : rcr_checker
bind rcr_top rcr_checker #(.PC_W(PC_W)) u_chk (.*);

// *** rcr_top_tb_top.sv ***
// Testbench for the reset cause recorder
`timescale 1ns/1ns
module rcr_top_tb_top;
  import rcr_pkg::*;
  typedef struct packed {
    rcr_cause_t c;
    logic s;
    logic e;
    logic [7:0] p;
    logic [7:0] st;
  } rcr_row_t;
  logic clk, rst_n, wr, rd, en, global_irq_enable, irqw, slp, clrw, idone, pcl, pcc, push, sen;
  logic [RCR_ADDR_W-1:0] addr;
  logic [RCR_DATA_W-1:0] wdata, rdata, d;
  logic [RCR_PC_W-1:0] pca;
  rcr_cause_t cz;
  int n_mismatch = 0;
  int checks_done = 0;
  rcr_row_t rows [14];
  rcr_top u_dut (.MCLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .POWERON_REQ(cz.poweron), .BROWNOUT_REQ(cz.brownout),
    .LP_BROWNOUT_REQ(cz.lp_brownout), .PROG_MODE_EXIT(cz.prog_exit),
    .EXT_PIN_RESET(cz.ext_pin), .WATCHDOG_TIMEOUT(cz.watchdog), .RESET_INSTR(cz.reset_instr),
    .STACK_OVERFLOW(cz.stack_over), .STACK_UNDERFLOW(cz.stack_under),
    .STACK_FAULT_RESET_ENABLE(en), .GLOBAL_IRQ_ENABLE(global_irq_enable), .IRQ_WAKE(irqw), .IN_SLEEP(slp),
    .SLEEP_ENTER(sen), .CLEAR_WATCHDOG(clrw), .INSTR_DONE(idone), .PC_LOAD(pcl),
    .PC_ADDR(pca), .PC_CONTINUE(pcc), .STACK_PUSH(push));
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrr(logic [3:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    clrw <= 1'h0;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wrr
  // Leaves the read data in d, one cycle after the strobe
  task automatic rdr(logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask : rdr
  task automatic ev(rcr_cause_t c, logic s, logic e);
    @(posedge clk);
    cz <= c;
    slp <= s;
    en <= e;
    @(posedge clk);
    cz <= '0;
    slp <= 1'h0;
  endtask : ev
  task automatic results();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    #300000;
    n_mismatch++;
    results();
  end
  initial begin
    {rst_n, wr, rd, en, global_irq_enable, irqw, slp, clrw, idone, sen} = '0;
    addr = '0;
    wdata = '0;
    cz = '0;
    rows = '{'{9'h010, 1'h0, 1'h0, 8'h17, 8'h18}, '{9'h010, 1'h1, 1'h0, 8'h17, 8'h10},
      '{9'h008, 1'h1, 1'h0, 8'h1F, 8'h00}, '{9'h008, 1'h0, 1'h0, 8'h0F, 8'h08},
      '{9'h004, 1'h0, 1'h0, 8'h1B, 8'h18}, '{9'h002, 1'h0, 1'h1, 8'h9F, 8'h18},
      '{9'h001, 1'h0, 1'h1, 8'h5F, 8'h18}, '{9'h002, 1'h0, 1'h0, 8'h1F, 8'h18},
      '{9'h080, 1'h0, 1'h0, 8'h1E, 8'h18}, '{9'h040, 1'h0, 1'h0, 8'h1E, 8'h18},
      '{9'h100, 1'h0, 1'h0, 8'h1C, 8'h18}, '{9'h020, 1'h0, 1'h0, 8'h1C, 8'h18},
      '{9'h014, 1'h0, 1'h0, 8'h13, 8'h18}, '{9'h110, 1'h0, 1'h0, 8'h1C, 8'h18}};
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rdr(RCR_OFS_POWER_CONTROL_FLAGS);
    chk("power_control_flags reset", d, 8'h1C);
    rdr(RCR_OFS_CORE_STATUS_FLAGS);
    chk("status reset", d, 8'h18);
    foreach (rows[i]) begin
      clrw <= 1'h1;
      wrr(RCR_OFS_POWER_CONTROL_FLAGS, 8'h1F);
      ev(rows[i].c, rows[i].s, rows[i].e);
      rdr(RCR_OFS_POWER_CONTROL_FLAGS);
      chk("power_control_flags row", d, rows[i].p);
      rdr(RCR_OFS_CORE_STATUS_FLAGS);
      chk("status row", d, rows[i].st);
    end
    wrr(RCR_OFS_POWER_CONTROL_FLAGS, 8'h3F);
    rdr(RCR_OFS_POWER_CONTROL_FLAGS);
    chk("power_control_flags bit5", d, 8'h1F);
    wrr(RCR_OFS_CORE_STATUS_FLAGS, 8'h00);
    rdr(RCR_OFS_CORE_STATUS_FLAGS);
    chk("status write", d, 8'h18);
    rdr(4'h7);
    chk("unmapped", d, 8'h00);
    global_irq_enable <= 1'h1;
    @(posedge clk);
    irqw <= 1'h1;
    slp <= 1'h1;
    @(posedge clk);
    irqw <= 1'h0;
    slp <= 1'h0;
    idone <= 1'h1;
    #1 chk("continue", pcc, 1'h1);
    @(posedge clk);
    idone <= 1'h0;
    @(posedge clk);
    #1 chk("push load", {push, pcl}, 2'h3);
    chk("vector", pca, RCR_IRQ_VECTOR);
    global_irq_enable <= 1'h0;
    rdr(RCR_OFS_CORE_STATUS_FLAGS);
    chk("status wake", d, 8'h10);
    @(posedge clk);
    clrw <= 1'h1;
    @(posedge clk);
    clrw <= 1'h0;
    rdr(RCR_OFS_CORE_STATUS_FLAGS);
    chk("status clear", d, 8'h18);
    @(posedge clk);
    sen <= 1'h1;
    @(posedge clk);
    sen <= 1'h0;
    rdr(RCR_OFS_CORE_STATUS_FLAGS);
    chk("status sleep", d, 8'h10);
    ev(9'h010, 1'h0, 1'h0);
    #1 chk("pin pc", {pcl, pca}, {1'h1, RCR_RESET_VECTOR});
    results();
  end
endmodule : rcr_top_tb_top
